//--- core/rdc_read_data_chan.sv
`timescale 1ns/100ps
module rdc_read_data_chan
  import rdc_pkg::*;
#(
  parameter int ID_W   = RDC_ID_DEF,   // Read ID width.
  parameter int DATA_W = RDC_DATA_DEF, // Read data width.
  parameter int USER_W = RDC_USER_DEF  // User extension width.
)
(
  input  wire logic                 mclk,          // Interface clock.
  input  wire logic                 nrst,          // Async reset, low.
  input  wire logic                 src_valid,     // Network offers a beat.
  output logic                      src_ready,     // Beat taken this edge.
  input  wire rdc_src_beat_t        src_beat,      // Offered beat.
  output logic [ID_W-1:0]           r_id,          // Read data ID.
  output logic [DATA_W-1:0]         r_data,        // Read data.
  output logic [RDC_RESP_W-1:0]     r_resp,        // Read response.
  output logic                      r_last,        // Final beat.
  output logic [USER_W-1:0]         r_user,        // User extension.
  output logic                      r_valid,       // Beat valid.
  input  wire logic                 r_ready,       // Master takes beat.
  output logic                      r_trace,       // Trace flag.
  output logic                      r_loop,        // Loop flag.
  output logic                      r_idunq,       // Unique ID, high.
  output logic                      r_chunkv,      // Chunk info valid.
  output logic [RDC_LEN_W-1:0]      r_chunknum,    // Chunk number.
  output logic [DATA_W/128-1:0]     r_chunkstrb,   // Slice strobes.
  output logic [DATA_W/128*4-1:0]   r_tag,         // Tag per slice.
  input  wire logic [RDC_QOS_W-1:0] reset_sampled_priority_override, // Pin.
  output logic [RDC_QOS_W-1:0]      prio_override, // Captured override.
  output logic                      prio_captured, // Override captured.
  input  wire logic                 owo_enable_in, // Ordering pin.
  output logic                      owo_enable     // Ordering enable.
);

  localparam int NSL  = DATA_W / RDC_SLICE_W;
  localparam int NTAG = NSL * RDC_TAG_PER_SL;

  // All state of this module; the output beat lives in the buffer.
  typedef struct packed {
    logic [RDC_LEN_W-1:0] beat_cnt;
    logic [RDC_LEN_W-1:0] len;
    logic                 chunk_en;
    logic [RDC_QOS_W-1:0] qos_meta;
    logic [RDC_QOS_W-1:0] qos_sync;
    logic [RDC_QOS_W-1:0] qos_val;
    logic [1:0]           cap_cnt;
    logic                 captured;
    logic                 owo_meta;
    logic                 owo_sync;
  } rdc_state_t;

  rdc_state_t             st_reg;
  rdc_state_t             st_next;
  rdc_rbeat_t             beat;
  rdc_rbeat_t             out_beat;
  logic                   buf_ready;
  logic                   push;
  logic                   first;
  logic [RDC_LEN_W-1:0]   cur_len;
  logic                   cur_chunk;
  logic [NSL-1:0]         strb;
  logic [NSL-1:0]         all_slices;
  logic [NSL-1:0]         first_slices;
  logic [RDC_TAG_MAX-1:0] tag_mask;

  // Widths beyond the package carriers cannot be served.
  initial
  begin
    if (ID_W < 1 || ID_W > RDC_ID_MAX)
      $error("rdc_read_data_chan: ID_W out of range.");
    if (DATA_W < RDC_SLICE_W || DATA_W > RDC_DATA_MAX ||
        (DATA_W % RDC_SLICE_W) != 0)
      $error("rdc_read_data_chan: DATA_W must be n*128 up to max.");
    if (USER_W < 1 || USER_W > RDC_USER_MAX)
      $error("rdc_read_data_chan: USER_W out of range.");
  end

  // Masks that select the slices this data width really has, and those from start_slice up.
  generate
    genvar g;
    for (g = 0; g < NSL; g = g + 1)
    begin : g_slice
      assign all_slices[g]   = 1'b1;
      assign first_slices[g] = (g >= int'(src_beat.start_slice));
    end
    for (g = 0; g < RDC_TAG_MAX; g = g + 1)
    begin : g_tag
      assign tag_mask[g] = (g < NTAG);
    end
  endgenerate

  // Build the outgoing beat and advance the per-transaction counters.
  always_comb
  begin
    st_next   = st_reg;
    push      = src_valid && buf_ready;
    first     = (st_reg.beat_cnt == RDC_BEAT_RST);
    cur_len   = first ? src_beat.len : st_reg.len;
    cur_chunk = first ? src_beat.chunk_en : st_reg.chunk_en;
    strb      = first ? first_slices : all_slices;

    beat          = '0;
    beat.id       = src_beat.id;
    beat.data     = src_beat.data;
    beat.resp     = src_beat.resp;
    beat.user     = src_beat.user;
    beat.trace    = src_beat.trace;
    beat.loop     = src_beat.loop;
    beat.idunq    = src_beat.idunq;
    // The tag rides in the same buffer entry as its data word.
    beat.tag      = src_beat.tag & tag_mask;
    beat.last     = (st_reg.beat_cnt == cur_len);
    beat.chunkv   = cur_chunk;
    if (cur_chunk)
    begin
      // Chunk number is the beat index within the transaction.
      beat.chunknum                = st_reg.beat_cnt;
      beat.chunkstrb[NSL-1:0]      = strb;
    end

    if (push)
    begin
      if (first)
      begin
        st_next.len      = src_beat.len;
        st_next.chunk_en = src_beat.chunk_en;
      end
      if (beat.last)
        st_next.beat_cnt = RDC_BEAT_RST;
      else
        st_next.beat_cnt = st_reg.beat_cnt + 8'h01;
    end

    // Static pins pass two flops before anything looks at them.
    st_next.qos_meta = reset_sampled_priority_override;
    st_next.qos_sync = st_reg.qos_meta;
    st_next.owo_meta = owo_enable_in;
    st_next.owo_sync = st_reg.owo_meta;

    // The override is taken once, after the synchroniser has filled, so
    // a later wiggle on the pin has no effect until the next reset.
    if (!st_reg.captured)
    begin
      if (st_reg.cap_cnt == RDC_CAP_CYCLE)
      begin
        st_next.qos_val  = st_reg.qos_sync;
        st_next.captured = 1'b1;
      end
      else
        st_next.cap_cnt = st_reg.cap_cnt + 2'h1;
    end
  end

  // Single state register of the module.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      st_reg <= '{beat_cnt: RDC_BEAT_RST, len: RDC_BEAT_RST, chunk_en: 1'b0,
                  qos_meta: RDC_QOS_RST, qos_sync: RDC_QOS_RST,
                  qos_val: RDC_QOS_RST, cap_cnt: 2'h0, captured: 1'b0,
                  owo_meta: 1'b0, owo_sync: 1'b0};
    else
      st_reg <= st_next;
  end

  // Two entries so that a stalled master loses no beat.
  rdc_skid_buf #(
    .W ($bits(rdc_rbeat_t))
  ) u_buf (
    .mclk    (mclk),
    .nrst    (nrst),
    .s_valid (src_valid),
    .s_ready (buf_ready),
    .s_data  (beat),
    .m_valid (r_valid),
    .m_ready (r_ready),
    .m_data  (out_beat)
  );

  // Outputs are slices of buffer and state flops.
  assign src_ready     = buf_ready;
  assign r_id          = out_beat.id[ID_W-1:0];
  assign r_data        = out_beat.data[DATA_W-1:0];
  assign r_resp        = out_beat.resp;
  assign r_last        = out_beat.last;
  assign r_user        = out_beat.user[USER_W-1:0];
  assign r_trace       = out_beat.trace;
  assign r_loop        = out_beat.loop;
  assign r_idunq       = out_beat.idunq;
  assign r_chunkv      = out_beat.chunkv;
  assign r_chunknum    = out_beat.chunknum;
  assign r_chunkstrb   = out_beat.chunkstrb[NSL-1:0];
  assign r_tag         = out_beat.tag[NTAG-1:0];
  assign prio_override = st_reg.qos_val;
  assign prio_captured = st_reg.captured;
  assign owo_enable    = st_reg.owo_sync;

endmodule

//--- core/rdc_pkg.sv
package rdc_pkg;

  // Each chunk strobe bit and each tag nibble covers one slice of this width.
  localparam int RDC_SLICE_W      = 128;
  localparam int RDC_TAG_PER_SL   = 4;
  localparam int RDC_DATA_MAX     = 256;
  localparam int RDC_SLICE_MAX    = RDC_DATA_MAX / RDC_SLICE_W;
  localparam int RDC_SLICE_IDX_W  = (RDC_SLICE_MAX > 1) ? $clog2(RDC_SLICE_MAX) : 1;
  localparam int RDC_TAG_MAX      = RDC_SLICE_MAX * RDC_TAG_PER_SL;
  localparam int RDC_ID_MAX       = 16;
  localparam int RDC_USER_MAX     = 8;
  localparam int RDC_RESP_W       = 4;
  localparam int RDC_LEN_W        = 8;
  localparam int RDC_QOS_W        = 4;

  // Default configuration of the interface.
  localparam int RDC_DATA_DEF     = 256;
  localparam int RDC_ID_DEF       = 8;
  localparam int RDC_USER_DEF     = 4;

  // Cycle after reset release at which the priority override is captured.
  localparam logic [1:0] RDC_CAP_CYCLE = 2'h2;

  // Reset values.
  localparam logic [RDC_LEN_W-1:0] RDC_BEAT_RST = 8'h00;
  localparam logic [RDC_QOS_W-1:0] RDC_QOS_RST  = 4'h0;

  // One beat as the network side offers it.
  typedef struct packed {
    logic [RDC_ID_MAX-1:0]      id;
    logic [RDC_DATA_MAX-1:0]    data;
    logic [RDC_RESP_W-1:0]      resp;
    logic [RDC_USER_MAX-1:0]    user;
    logic                       trace;
    logic                       loop;
    logic                       idunq;
    logic                       chunk_en;
    logic [RDC_SLICE_IDX_W-1:0] start_slice;
    logic [RDC_LEN_W-1:0]       len;
    logic [RDC_TAG_MAX-1:0]     tag;
  } rdc_src_beat_t;

  // One beat as it leaves on the read data channel.
  typedef struct packed {
    logic [RDC_ID_MAX-1:0]    id;
    logic [RDC_DATA_MAX-1:0]  data;
    logic [RDC_RESP_W-1:0]    resp;
    logic                     last;
    logic [RDC_USER_MAX-1:0]  user;
    logic                     trace;
    logic                     loop;
    logic                     idunq;
    logic                     chunkv;
    logic [RDC_LEN_W-1:0]     chunknum;
    logic [RDC_SLICE_MAX-1:0] chunkstrb;
    logic [RDC_TAG_MAX-1:0]   tag;
  } rdc_rbeat_t;

endpackage

//--- core/rdc_skid_buf.sv
`timescale 1ns/100ps
module rdc_skid_buf
  import rdc_pkg::*;
#(
  parameter int W = 8
)
(
  input  wire logic         mclk,    // Interface clock.
  input  wire logic         nrst,    // Asynchronous reset, active low.
  input  wire logic         s_valid, // Fill side offers a word.
  output logic              s_ready, // Room for a word, from a flop.
  input  wire logic [W-1:0] s_data,  // Word offered.
  output logic              m_valid, // Head word valid, decoded from the count flops.
  input  wire logic         m_ready, // Drain side takes the head.
  output logic [W-1:0]      m_data   // Head word, from a flop.
);

  typedef struct packed {
    logic [1:0]   cnt;
    logic         rdy;
    logic [W-1:0] head;
    logic [W-1:0] tail;
  } rdc_buf_st_t;

  rdc_buf_st_t st_reg;
  rdc_buf_st_t st_next;
  logic        push;
  logic        pop;

  initial
  begin
    if (W < 1)
      $error("rdc_skid_buf: W must be positive.");
  end

  // Two entries keep full throughput even though ready is registered.
  always_comb
  begin
    st_next = st_reg;
    push    = s_valid && st_reg.rdy;
    pop     = m_ready && (st_reg.cnt != 2'h0);
    case ({push, pop})
      2'b10:
      begin
        if (st_reg.cnt == 2'h0)
          st_next.head = s_data;
        else
          st_next.tail = s_data;
        st_next.cnt = st_reg.cnt + 2'h1;
      end
      2'b01:
      begin
        st_next.head = st_reg.tail;
        st_next.cnt  = st_reg.cnt - 2'h1;
      end
      2'b11:
      begin
        if (st_reg.cnt == 2'h1)
          st_next.head = s_data;
        else
        begin
          st_next.head = st_reg.tail;
          st_next.tail = s_data;
        end
      end
      default:
      begin
        st_next.cnt = st_reg.cnt;
      end
    endcase
    st_next.rdy = (st_next.cnt != 2'h2);
  end

  // The head stays put until the drain side takes it.
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      st_reg <= '{cnt: 2'h0, rdy: 1'b1, head: '0, tail: '0};
    else
      st_reg <= st_next;
  end

  assign s_ready = st_reg.rdy;
  assign m_valid = (st_reg.cnt != 2'h0);
  assign m_data  = st_reg.head;

endmodule

//--- verif/rdc_read_data_chan_checker.sv
`timescale 1ns/100ps
module rdc_read_data_chan_checker
  import rdc_pkg::*;
#(
  parameter int DATA_W = RDC_DATA_DEF
)
(
  input wire logic                   mclk,        // Clock.
  input wire logic                   nrst,        // Reset.
  input wire logic                   src_valid,   // Offer.
  input wire logic                   src_ready,   // Taken.
  input wire logic                   r_valid,     // Beat valid.
  input wire logic                   r_ready,     // Master ready.
  input wire logic [DATA_W-1:0]      r_data,      // Data.
  input wire logic                   r_last,      // Last.
  input wire logic [DATA_W/128*4-1:0] r_tag,      // Tags.
  input wire logic                   r_chunkv,    // Chunk valid.
  input wire logic [RDC_LEN_W-1:0]   r_chunknum,  // Chunk number.
  input wire logic [DATA_W/128-1:0]  r_chunkstrb, // Strobes.
  input wire logic [RDC_QOS_W-1:0]   reset_sampled_priority_override, // Pin.
  input wire logic [RDC_QOS_W-1:0]   prio_override, // Held.
  input wire logic                   prio_captured, // Taken.
  input wire logic                   owo_enable_in, // Pin.
  input wire logic                   owo_enable     // Enable.
);
  // Every check runs on the interface clock and sleeps in reset.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_beat_held: assert property (
    r_valid && !r_ready |=> r_valid && $stable({r_data, r_last, r_tag}))
    else $error("Beat changed while stalled.");
  a_chunk_idle: assert property (
    !r_chunkv |-> r_chunknum == 8'h00 && r_chunkstrb == '0)
    else $error("Chunk fields set without chunk valid.");
  a_strb_later: assert property (
    r_valid && r_chunkv && r_chunknum != 8'h00 |-> &r_chunkstrb)
    else $error("Later chunk lacks full strobes.");
  a_answer_next: assert property (
    src_valid && src_ready && !r_valid |=> r_valid)
    else $error("Taken beat not offered next cycle.");
  a_prio_kept: assert property (
    prio_captured |=> prio_captured && $stable(prio_override))
    else $error("Captured override moved.");
  a_prio_taken: assert property (
    $rose(prio_captured) |-> prio_override == reset_sampled_priority_override)
    else $error("Override captured wrong value.");
  a_owo_on: assert property (
    owo_enable_in [*3] |=> owo_enable)
    else $error("Ordering enable missing.");
  a_owo_off: assert property (
    !owo_enable_in [*3] |=> !owo_enable)
    else $error("Ordering enable stuck.");

  // Stall, refusal and final beat must all be seen.
  c_stall: cover property (r_valid && !r_ready);
  c_full: cover property (!src_ready);
  c_last: cover property (r_valid && r_ready && r_last);
endmodule

bind rdc_read_data_chan rdc_read_data_chan_checker #(.DATA_W(DATA_W))
  rdc_chk (.mclk, .nrst, .src_valid, .src_ready, .r_valid, .r_ready,
  .r_data, .r_last, .r_tag, .r_chunkv, .r_chunknum, .r_chunkstrb,
  .reset_sampled_priority_override, .prio_override, .prio_captured,
  .owo_enable_in, .owo_enable);

//--- verif/rdc_master_model.sv
`timescale 1ns/100ps
module rdc_master_model
(
  input  wire logic mclk,    // Clock.
  input  wire logic nrst,    // Reset, active low.
  input  wire logic slow,    // Ready every other cycle.
  input  wire logic hold,    // Refuse every beat.
  input  wire logic r_valid, // Beat offered.
  output logic      r_ready  // Beat taken.
);
  // Ready moves only after an edge, so a beat transfers on valid and ready.
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
      r_ready <= 1'b0;
    else
      r_ready <= !hold && (!slow || !r_ready);
endmodule

//--- verif/rdc_read_data_chan_tb.sv
`timescale 1ns/100ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
  fails++; $display("[ERR] %s expected %h seen %h", n, e, s); end end
module rdc_read_data_chan_tb;
  import rdc_pkg::*;
  logic          mclk, nrst, src_valid, src_ready, r_last, r_valid;
  logic          r_ready, r_idunq, r_chunkv, slow, hold;
  logic          prio_captured, owo_enable_in, owo_enable;
  logic          r_trace, r_loop;
  logic [7:0]    r_id;
  logic [3:0]    r_user;
  logic [3:0]    r_resp, reset_sampled_priority_override, prio_override;
  logic [7:0]    r_chunknum, r_tag;
  logic [1:0]    r_chunkstrb;
  logic [255:0]  r_data;
  rdc_src_beat_t src_beat;
  logic [46:0]   got_q[$];
  int            fails = 0;
  int            samples_checked = 0;

  rdc_read_data_chan rdc_read_data_chan_inst (.mclk, .nrst, .src_valid,
    .src_ready, .src_beat, .r_id, .r_data, .r_resp, .r_last, .r_user,
    .r_valid, .r_ready, .r_trace, .r_loop, .r_idunq, .r_chunkv,
    .r_chunknum, .r_chunkstrb, .r_tag, .reset_sampled_priority_override,
    .prio_override, .prio_captured, .owo_enable_in, .owo_enable);
  rdc_master_model rdc_master_model_inst (.mclk, .nrst, .slow, .hold,
    .r_valid, .r_ready);

  // Free-running interface clock.
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Record every beat the master accepts.
  always @(posedge mclk)
    if (nrst && r_valid === 1'b1 && r_ready === 1'b1)
      got_q.push_back({r_id, r_user, r_trace, r_loop, r_last, r_chunkv,
                       r_chunknum, r_chunkstrb, r_tag, r_idunq, r_resp,
                       r_data[135:128]});

  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Reset with an override value, then move the pin and expect it ignored.
  task automatic prio(input logic [3:0] v);
    nrst <= 1'b0;
    reset_sampled_priority_override <= v;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
    reset_sampled_priority_override <= ~v;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    `CHK("prio", v, prio_override)
    `CHK("captured", 1'b1, prio_captured)
    $display("override test %h done", v);
  endtask

  // Offer one beat and hold it until the edge that takes it.
  task automatic send(input int k, input logic [7:0] ln, input logic ce, ss);
    rdc_src_beat_t b;
    int t;
    b = '0;
    t = 0;
    b.len = ln;
    b.chunk_en = ce;
    b.start_slice = ss;
    b.data[135:128] = 8'(k);
    b.tag = {k[3:0] ^ 4'h5, k[3:0]};
    b.resp = k[3:0];
    b.idunq = k[0];
    b.id = 16'(k + 8'h40);
    b.user = 8'(k[3:0] ^ 4'ha);
    b.trace = k[1];
    b.loop = !k[0];
    src_valid <= 1'b1;
    src_beat <= b;
    @(negedge mclk);
    while (src_ready !== 1'b1 && t < 50)
    begin
      @(negedge mclk);
      t++;
    end
    if (t == 50)
    begin
      fails++;
      end_sim();
    end
    @(posedge mclk);
  endtask

  // One transaction; md[0] stalls the master, md[1] fills the buffer first.
  task automatic burst(input logic [7:0] ln, input logic ce, ss,
                       input logic [1:0] md);
    logic [1:0] sb;
    int t;
    t = 0;
    got_q.delete();
    slow <= md[0];
    hold <= md[1];
    @(posedge mclk);
    fork
      begin
        for (int k = 0; k <= ln; k++)
          send(k, ln, ce, ss);
        src_valid <= 1'b0;
      end
      if (md[1])
      begin
        repeat (8) @(negedge mclk);
        `CHK("src_ready", 1'b0, src_ready)
        `CHK("early", 0, got_q.size())
        @(posedge mclk);
        hold <= 1'b0;
      end
    join
    while (got_q.size() <= ln && t < 200)
    begin
      @(posedge mclk);
      t++;
    end
    `CHK("count", ln + 1, got_q.size())
    if (t == 200)
      end_sim();
    for (int k = 0; k <= ln && k < got_q.size(); k++)
    begin
      sb = !ce ? 2'b00 : (k == 0 && ss) ? 2'b10 : 2'b11;
      `CHK("side", {8'(k + 8'h40), k[3:0] ^ 4'ha, k[1], !k[0]}, got_q[k][46:33])
      `CHK("beat", {k == ln, ce, ce ? 8'(k) : 8'h00, sb,
                    k[3:0] ^ 4'h5, k[3:0], k[0], k[3:0], 8'(k)},
           got_q[k][32:0])
    end
    $display("burst len %0d mode %0d done", ln, md);
  endtask

  // Ordering enable follows its pin two edges later.
  task automatic owo(input logic v);
    @(posedge mclk);
    owo_enable_in <= v;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    `CHK("owo", v, owo_enable)
    $display("ordering test %0d done", v);
  endtask

  // Main sequence.
  initial
  begin
    nrst = 1'b0;
    src_valid = 1'b0;
    src_beat = '0;
    slow = 1'b0;
    hold = 1'b0;
    owo_enable_in = 1'b0;
    reset_sampled_priority_override = 4'h0;
    prio(4'h9);
    burst(8'h03, 1'b1, 1'b0, 2'b00);
    burst(8'h01, 1'b1, 1'b1, 2'b01);
    burst(8'h03, 1'b0, 1'b0, 2'b10);
    burst(8'h00, 1'b1, 1'b0, 2'b00);
    owo(1'b1);
    owo(1'b0);
    prio(4'h6);
    burst(8'h02, 1'b1, 1'b0, 2'b01);
    end_sim();
  end
endmodule
